// File: design/pwc_cfg.svh
/*
  Register map, field positions, reset values and link framing for the
  lamp switch, auxiliary output and glass driver control block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef PWC_CFG_SVH
`define PWC_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PWC_ADDR_W            4
`define PWC_DATA_W            8
`define PWC_OFS_SYS_CTRL      4'h0
`define PWC_OFS_LAMP_OUT      4'h2
`define PWC_OFS_LAMP_STAT     4'h4
`define PWC_OFS_GLASS_CTRL    4'h5
`define PWC_OFS_GLASS_DAC     4'h6
`define PWC_RESET_VAL         8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PWC_SYS_PSE_BIT       7
`define PWC_SYS_STOP_BIT      6
`define PWC_SYS_SLEEP_BIT     5
`define PWC_SYS_CFG_MASK      8'h1f
`define PWC_SYS_VSS_BIT       2
`define PWC_OUT_AUX_BIT       7
`define PWC_OUT_PWM_LSB       3
`define PWC_OUT_ON_LSB        0
`define PWC_OUT_RW_MASK       8'hbf
`define PWC_STAT_AUX_BIT      3
`define PWC_GLS_VT_BIT        7
`define PWC_GLS_OLT_BIT       6
`define PWC_GLS_RT_BIT        5
`define PWC_GLS_OCF_BIT       1
`define PWC_GLS_OLF_BIT       0
`define PWC_DAC_MASK          8'h3f

// ----------------------------------------------------------------------
// Serial link framing
// ----------------------------------------------------------------------
`define PWC_SPI_FRAME_BITS    5'h10
`define PWC_SPI_HDR_BITS      5'h08
`define PWC_SPI_WR_BIT        7

`endif

// File: design/pwc_pkg.sv
/*
  Types shared by the power output control block.
  Assumes pwc_cfg.svh holds the numeric constants.
*/
package pwc_pkg;
  typedef logic [7:0] pwc_byte_type;
  typedef logic [3:0] pwc_addr_type;

  typedef enum logic [1:0] {
    PWC_LAMP_OFF    = 2'b00,
    PWC_LAMP_ON     = 2'b01,
    PWC_LAMP_PWM    = 2'b10,
    PWC_LAMP_INRUSH = 2'b11
  } pwc_lamp_mode_type;
endpackage : pwc_pkg

// File: design/pwc_spi_slave.sv
/*
  Serial register link slave: 16-bit frames, MSB first, sample on SCK
  rising, shift on SCK falling. Byte 0 = {write, 3'b0, address}, byte 1 =
  write data in, read data out. The write is applied at SS release.
  Assumes link pins are synchronous to i_clk_sys and SCK is much slower.
*/
`timescale 1ns/1ns
`include "pwc_cfg.svh"

module pwc_spi_slave
  import pwc_pkg::*;
(
  input  wire logic          i_clk_sys,   // System clock
  input  wire logic          i_rstn,      // Async reset, low
  input  wire logic          i_ss_n,      // Slave select, low
  input  wire logic          i_sck,       // Serial clock
  input  wire logic          i_mosi,      // Serial data in
  output logic               o_miso,      // Serial data out
  output pwc_pkg::pwc_addr_type o_addr,   // Register address
  input  wire pwc_pkg::pwc_byte_type i_rd_data, // Read data
  output logic               o_wr_en,     // Write pulse
  output pwc_pkg::pwc_byte_type o_wr_data // Write data
);
  import pwc_pkg::*;

  logic         sck_d_r,  sck_d_nxt;
  logic         ss_d_r,   ss_d_nxt;
  logic [4:0]   cnt_r,    cnt_nxt;
  logic [14:0]  sh_in_r,  sh_in_nxt;
  pwc_byte_type miso_r,   miso_nxt;
  pwc_addr_type addr_r,   addr_nxt;
  logic         wr_r,     wr_nxt;
  logic         wr_en_r,  wr_en_nxt;
  pwc_byte_type wdata_r,  wdata_nxt;
  logic         rise;
  logic         fall;

  // --------------------------------------------------------------------
  // Frame shifter
  // --------------------------------------------------------------------
  always_comb begin
    rise      = i_sck & ~sck_d_r & ~i_ss_n;
    fall      = ~i_sck & sck_d_r & ~i_ss_n;
    sck_d_nxt = i_sck;
    ss_d_nxt  = i_ss_n;
    cnt_nxt   = cnt_r;
    sh_in_nxt = sh_in_r;
    miso_nxt  = miso_r;
    addr_nxt  = addr_r;
    wr_nxt    = wr_r;
    wr_en_nxt = 1'b0;
    wdata_nxt = wdata_r;
    if (i_ss_n) begin
      cnt_nxt  = 5'h00;
      miso_nxt = 8'h00;
      // Only a complete frame writes; short frames are dropped
      if (!ss_d_r && cnt_r == `PWC_SPI_FRAME_BITS && wr_r) begin
        wr_en_nxt = 1'b1;
        wdata_nxt = sh_in_r[7:0];
      end
    end else begin
      if (rise && cnt_r != `PWC_SPI_FRAME_BITS) begin
        sh_in_nxt = {sh_in_r[13:0], i_mosi};
        cnt_nxt   = cnt_r + 5'h01;
        if (cnt_r == `PWC_SPI_HDR_BITS - 5'h01) begin
          addr_nxt = {sh_in_r[2:0], i_mosi};
          wr_nxt   = sh_in_r[6];
        end
      end
      if (fall && cnt_r == `PWC_SPI_HDR_BITS) begin
        miso_nxt = i_rd_data;
      end else if (fall && cnt_r > `PWC_SPI_HDR_BITS) begin
        miso_nxt = {miso_r[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      sck_d_r <= 1'b0;
      ss_d_r  <= 1'b1;
      cnt_r   <= 5'h00;
      sh_in_r <= 15'h0000;
      miso_r  <= 8'h00;
      addr_r  <= 4'h0;
      wr_r    <= 1'b0;
      wr_en_r <= 1'b0;
      wdata_r <= 8'h00;
    end else begin
      sck_d_r <= sck_d_nxt;
      ss_d_r  <= ss_d_nxt;
      cnt_r   <= cnt_nxt;
      sh_in_r <= sh_in_nxt;
      miso_r  <= miso_nxt;
      addr_r  <= addr_nxt;
      wr_r    <= wr_nxt;
      wr_en_r <= wr_en_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  assign o_miso    = miso_r[7];
  assign o_addr    = addr_r;
  assign o_wr_en   = wr_en_r;
  assign o_wr_data = wdata_r;
endmodule : pwc_spi_slave

// File: design/pwc_power_output_control.sv
/*
  Lamp switch, auxiliary 5 V output and dimming glass control with the
  system control register, reached over the serial register link.
  Assumes fault detector and PWM inputs are synchronous to i_clk_sys;
  analog sensing, thermal/voltage monitors and watchdog live elsewhere.
*/
`timescale 1ns/1ns
`include "pwc_cfg.svh"

module pwc_power_output_control
  import pwc_pkg::*;
#(
  parameter int LAMPS = 3                       // Lamp switch count
)(
  input  wire logic             i_clk_sys,      // System clock 50 MHz
  input  wire logic             i_rstn,         // Async reset, low
  input  wire logic             i_ss_n,         // Link select, low
  input  wire logic             i_sck,          // Link clock
  input  wire logic             i_mosi,         // Link data in
  output logic                  o_miso,         // Link data out
  input  wire logic             i_pwm,          // PWM input
  input  wire logic [LAMPS-1:0] i_lamp_oc,      // Lamp over-current detect
  input  wire logic             i_aux_oc,       // Aux over-current detect
  input  wire logic             i_glass_short,  // Glass short detect
  input  wire logic             i_glass_above,  // Glass pin above threshold
  input  wire logic             i_low_voltage_fault_flag,  // Low voltage fault
  input  wire logic             i_high_voltage_fault_flag, // High voltage fault
  output logic [LAMPS-1:0]      o_lamp_switch,  // Lamp switch gate drive
  output logic                  o_aux_5v_output,// Aux output enable
  output logic                  o_aux_current_limit, // Aux limiting active
  output logic                  o_supply_switch_transistor, // Glass supply switch
  output logic                  o_dac_output_transistor,    // Glass DAC stage
  output logic                  o_glass_open_load_current,  // Test source on
  output logic [5:0]            o_glass_dac_code,           // Glass DAC code
  output logic                  o_power_stage_enable,       // Power stages on
  output logic                  o_stop_req,     // Stop request pulse
  output logic                  o_sleep_req,    // Sleep request pulse
  output logic                  o_high_side_thermal_shutdown_select, // HS thermal
  output logic                  o_low_side_thermal_shutdown_select,  // LS thermal
  output logic                  o_voltage_shutdown_select,  // Voltage select
  output logic [1:0]            o_line_slew_select          // Line slew
);
  import pwc_pkg::*;

  pwc_addr_type addr;
  pwc_byte_type wr_data;
  pwc_byte_type rd_data;
  logic         wr_en;

  // --------------------------------------------------------------------
  // Register link
  // --------------------------------------------------------------------
  pwc_spi_slave u_link (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_ss_n    (i_ss_n),
    .i_sck     (i_sck),
    .i_mosi    (i_mosi),
    .o_miso    (o_miso),
    .o_addr    (addr),
    .i_rd_data (rd_data),
    .o_wr_en   (wr_en),
    .o_wr_data (wr_data)
  );

  logic wr_sys, wr_out, wr_stat, wr_gls, wr_dac;
  assign wr_sys  = wr_en && addr == `PWC_OFS_SYS_CTRL;
  assign wr_out  = wr_en && addr == `PWC_OFS_LAMP_OUT;
  assign wr_stat = wr_en && addr == `PWC_OFS_LAMP_STAT;
  assign wr_gls  = wr_en && addr == `PWC_OFS_GLASS_CTRL;
  assign wr_dac  = wr_en && addr == `PWC_OFS_GLASS_DAC;

  // --------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------
  logic         pse_r,    pse_nxt;
  logic [4:0]   syscfg_r, syscfg_nxt;
  logic         stop_r,   stop_nxt;
  logic         sleep_r,  sleep_nxt;
  pwc_byte_type out_r,    out_nxt;
  logic [5:0]   dac_r,    dac_nxt;
  logic         vt_en_r,  vt_en_nxt;
  logic         olt_r,    olt_nxt;
  logic         rt_en_r,  rt_en_nxt;
  logic         g_ocf_r,  g_ocf_nxt;
  logic         g_olf_r,  g_olf_nxt;
  logic         aux_ocf_r, aux_ocf_nxt;
  logic         aux_lim_r, aux_lim_nxt;
  logic         low_cmd;

  // Stop/sleep run only when PSE and bits 4:2 are zero; line slew bits 1:0 may be set
  assign low_cmd = (wr_data[7] == 1'b0) && (wr_data[4:2] == 3'h0);

  always_comb begin
    pse_nxt    = pse_r;
    syscfg_nxt = syscfg_r;
    stop_nxt   = 1'b0;
    sleep_nxt  = 1'b0;
    out_nxt    = out_r;
    dac_nxt    = dac_r;
    vt_en_nxt  = vt_en_r;
    olt_nxt    = olt_r;
    rt_en_nxt  = rt_en_r;
    g_ocf_nxt  = g_ocf_r;
    g_olf_nxt  = g_olf_r;
    aux_ocf_nxt = aux_ocf_r;
    aux_lim_nxt = i_aux_oc;
    if (wr_sys) begin
      pse_nxt    = wr_data[`PWC_SYS_PSE_BIT];
      syscfg_nxt = wr_data[4:0] & 5'(`PWC_SYS_CFG_MASK);
      stop_nxt   = wr_data[`PWC_SYS_STOP_BIT] & ~wr_data[`PWC_SYS_SLEEP_BIT] & low_cmd;
      sleep_nxt  = wr_data[`PWC_SYS_SLEEP_BIT] & ~wr_data[`PWC_SYS_STOP_BIT] & low_cmd;
    end
    if (wr_out) begin
      out_nxt = wr_data & `PWC_OUT_RW_MASK;
    end
    if (wr_dac) begin
      dac_nxt = wr_data[5:0];
    end
    if (wr_gls) begin
      vt_en_nxt = wr_data[`PWC_GLS_VT_BIT];
      olt_nxt   = wr_data[`PWC_GLS_OLT_BIT];
      rt_en_nxt = wr_data[`PWC_GLS_RT_BIT];
      if (wr_data[`PWC_GLS_OCF_BIT]) begin
        g_ocf_nxt = 1'b0;
      end
      if (wr_data[`PWC_GLS_OLF_BIT]) begin
        g_olf_nxt = 1'b0;
        vt_en_nxt = 1'b0;
        rt_en_nxt = 1'b0;
      end
    end
    if (wr_stat && wr_data[`PWC_STAT_AUX_BIT]) begin
      aux_ocf_nxt = 1'b0;
    end
    // Detector sets are last so they win over a same-cycle clear
    if (i_aux_oc) begin
      aux_ocf_nxt = 1'b1;
    end
    if (i_glass_short) begin
      g_ocf_nxt = 1'b1;
    end
    if (olt_r && i_glass_above) begin
      g_olf_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      pse_r     <= 1'b0;
      syscfg_r  <= 5'h00;
      stop_r    <= 1'b0;
      sleep_r   <= 1'b0;
      out_r     <= `PWC_RESET_VAL;
      dac_r     <= 6'h00;
      vt_en_r   <= 1'b0;
      olt_r     <= 1'b0;
      rt_en_r   <= 1'b0;
      g_ocf_r   <= 1'b0;
      g_olf_r   <= 1'b0;
      aux_ocf_r <= 1'b0;
      aux_lim_r <= 1'b0;
    end else begin
      pse_r     <= pse_nxt;
      syscfg_r  <= syscfg_nxt;
      stop_r    <= stop_nxt;
      sleep_r   <= sleep_nxt;
      out_r     <= out_nxt;
      dac_r     <= dac_nxt;
      vt_en_r   <= vt_en_nxt;
      olt_r     <= olt_nxt;
      rt_en_r   <= rt_en_nxt;
      g_ocf_r   <= g_ocf_nxt;
      g_olf_r   <= g_olf_nxt;
      aux_ocf_r <= aux_ocf_nxt;
      aux_lim_r <= aux_lim_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Lamp switches
  // --------------------------------------------------------------------
  logic             pwm_d_r, pwm_d_nxt;
  logic             pwm_rise;
  logic             v_block;
  logic [LAMPS-1:0] ocf_r,  ocf_nxt;
  logic [LAMPS-1:0] trip_r, trip_nxt;
  logic [LAMPS-1:0] sw_r,   sw_nxt;

  assign pwm_d_nxt = i_pwm;
  assign pwm_rise  = i_pwm & ~pwm_d_r;
  // Voltage faults block lamps while syscfg_r bit PWC_SYS_VSS_BIT is clear, but never the aux output
  assign v_block   = (i_low_voltage_fault_flag | i_high_voltage_fault_flag)
                     & ~syscfg_r[`PWC_SYS_VSS_BIT];

  for (genvar g = 0; g < LAMPS; g++) begin : g_lamp
    pwc_lamp_mode_type mode;
    logic              clr;
    assign mode = pwc_lamp_mode_type'({out_r[`PWC_OUT_PWM_LSB + g], out_r[`PWC_OUT_ON_LSB + g]});
    assign clr  = wr_stat & wr_data[g];

    always_comb begin
      ocf_nxt[g]  = ocf_r[g];
      trip_nxt[g] = trip_r[g];
      if (clr) begin
        ocf_nxt[g]  = 1'b0;
        trip_nxt[g] = 1'b0;
      end
      // Any PWM rising edge re-arms, whatever the duty cycle
      if (pwm_rise) begin
        trip_nxt[g] = 1'b0;
      end
      if (i_lamp_oc[g] && sw_r[g]) begin
        ocf_nxt[g]  = 1'b1;
        trip_nxt[g] = 1'b1;
      end
      unique case (mode)
        PWC_LAMP_OFF:    sw_nxt[g] = 1'b0;
        PWC_LAMP_ON:     sw_nxt[g] = ~ocf_nxt[g];
        PWC_LAMP_PWM:    sw_nxt[g] = i_pwm & ~trip_nxt[g];
        PWC_LAMP_INRUSH: sw_nxt[g] = ~trip_nxt[g];
      endcase
      if (!pse_r || v_block) begin
        sw_nxt[g] = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      pwm_d_r <= 1'b0;
      ocf_r   <= '0;
      trip_r  <= '0;
      sw_r    <= '0;
    end else begin
      pwm_d_r <= pwm_d_nxt;
      ocf_r   <= ocf_nxt;
      trip_r  <= trip_nxt;
      sw_r    <= sw_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------
  always_comb begin
    rd_data = 8'h00;
    unique case (addr)
      `PWC_OFS_SYS_CTRL:   rd_data = {pse_r, 2'b00, syscfg_r};
      `PWC_OFS_LAMP_OUT:   rd_data = out_r & `PWC_OUT_RW_MASK;
      `PWC_OFS_LAMP_STAT:  rd_data = {4'h0, aux_ocf_r, ocf_r};
      `PWC_OFS_GLASS_CTRL: rd_data = {vt_en_r, olt_r, rt_en_r, 3'b000,
                                      g_ocf_r, g_olf_r};
      `PWC_OFS_GLASS_DAC:  rd_data = {2'b00, dac_r} & `PWC_DAC_MASK;
      default:             rd_data = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign o_lamp_switch        = sw_r;
  assign o_aux_5v_output      = pse_r & out_r[`PWC_OUT_AUX_BIT];
  assign o_aux_current_limit  = aux_lim_r;
  // Short or open-load test stops both glass transistors
  assign o_dac_output_transistor    = vt_en_r & ~olt_r & ~g_ocf_r;
  assign o_supply_switch_transistor = rt_en_r & ~olt_r & ~g_ocf_r;
  assign o_glass_open_load_current  = olt_r;
  assign o_glass_dac_code     = dac_r;
  assign o_power_stage_enable = pse_r;
  assign o_stop_req           = stop_r;
  assign o_sleep_req          = sleep_r;
  assign o_high_side_thermal_shutdown_select = syscfg_r[3];
  assign o_low_side_thermal_shutdown_select  = syscfg_r[4];
  assign o_voltage_shutdown_select           = syscfg_r[`PWC_SYS_VSS_BIT];
  assign o_line_slew_select   = syscfg_r[1:0];
endmodule : pwc_power_output_control

// File: dv/pwc_poc_asserts.sv
/*
  Port-level checks on the power output control block.
  Assumes it is bound onto pwc_power_output_control, one clock domain.
*/
`timescale 1ns/1ns

module pwc_poc_asserts #(
  parameter int LAMPS = 3                       // Lamp switch count
)(
  input wire logic             i_clk_sys,       // System clock
  input wire logic             i_rstn,          // Async reset, low
  input wire logic             i_pwm,           // PWM input
  input wire logic [LAMPS-1:0] i_lamp_oc,       // Lamp over-current
  input wire logic             i_aux_oc,        // Aux over-current
  input wire logic             i_glass_short,   // Glass short
  input wire logic             i_low_voltage_fault_flag,  // Low voltage
  input wire logic             i_high_voltage_fault_flag, // High voltage
  input wire logic [LAMPS-1:0] o_lamp_switch,   // Lamp drive
  input wire logic             o_aux_5v_output, // Aux output
  input wire logic             o_aux_current_limit,        // Aux limiting
  input wire logic             o_supply_switch_transistor, // Glass supply
  input wire logic             o_dac_output_transistor,    // Glass DAC stage
  input wire logic             o_glass_open_load_current,  // Test source
  input wire logic             o_power_stage_enable,       // Power stages
  input wire logic             o_stop_req,      // Stop pulse
  input wire logic             o_sleep_req,     // Sleep pulse
  input wire logic             o_voltage_shutdown_select   // Voltage select
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  a_aux_needs_pse: assert property (o_aux_5v_output |-> o_power_stage_enable)
    else $error("aux output on without power enable");
  a_pse_off_lamps: assert property (!o_power_stage_enable [*2] |-> o_lamp_switch == '0)
    else $error("lamp on while power stages disabled");
  a_vfault_lamps_off: assert property ((i_low_voltage_fault_flag || i_high_voltage_fault_flag)
    && !o_voltage_shutdown_select |=> o_lamp_switch == '0)
    else $error("lamp on during voltage fault");
  a_aux_limit_on: assert property (i_aux_oc |=> o_aux_current_limit)
    else $error("aux over-current not limited");
  // Pwm held low so no re-arm edge can excuse the output
  a_lamp_trip_off: assert property (i_lamp_oc[0] && o_lamp_switch[0] && !i_pwm ##1 !i_pwm
    |-> !o_lamp_switch[0])
    else $error("lamp still on after over-current");
  a_test_stops_glass: assert property (o_glass_open_load_current
    |-> !o_supply_switch_transistor && !o_dac_output_transistor)
    else $error("glass driven during open-load test");
  a_short_stops_glass: assert property (i_glass_short
    |=> !o_supply_switch_transistor && !o_dac_output_transistor)
    else $error("glass driven after short");
  a_mode_req_pulse: assert property (o_stop_req || o_sleep_req
    |-> !(o_stop_req && o_sleep_req) ##1 !o_stop_req && !o_sleep_req)
    else $error("mode request not a single pulse");
endmodule : pwc_poc_asserts

bind pwc_power_output_control pwc_poc_asserts #(.LAMPS(LAMPS)) u_chk (.i_clk_sys, .i_rstn, .i_pwm,
  .i_lamp_oc, .i_aux_oc, .i_glass_short, .i_low_voltage_fault_flag, .i_high_voltage_fault_flag,
  .o_lamp_switch, .o_aux_5v_output, .o_aux_current_limit, .o_supply_switch_transistor,
  .o_dac_output_transistor, .o_glass_open_load_current, .o_power_stage_enable, .o_stop_req,
  .o_sleep_req, .o_voltage_shutdown_select);

// File: dv/pwc_link_master.sv
/*
  Controller-side model of the serial register link.
  Assumes the block samples the link pins on i_clk_sys.
*/
`timescale 1ns/1ns

module pwc_link_master #(
  parameter int HALF = 3          // Clocks per link clock phase
)(
  input  wire logic i_clk_sys,    // System clock
  input  wire logic i_miso,       // Data from block
  output logic      o_ss_n,       // Select, low
  output logic      o_sck,        // Link clock
  output logic      o_mosi        // Data to block
);
  // Data line idles low as its pull-down would leave it
  initial begin
    o_ss_n = 1'b1;
    o_sck  = 1'b0;
    o_mosi = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : tick

  // One 16-bit frame, address byte then data byte
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] frame;
    frame = {wr, 3'b000, a, d};
    q = 8'h00;
    tick(1);
    o_ss_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      o_mosi = frame[i];
      tick(HALF);
      o_sck = 1'b1;
      if (i < 8) q[i] = i_miso;
      tick(HALF);
      o_sck = 1'b0;
    end
    tick(HALF);
    o_ss_n = 1'b1;
    o_mosi = 1'b0;
    tick(4);
  endtask : xfer
endmodule : pwc_link_master

// File: dv/tb_top.sv
/*
  Register-level testbench for the power output control block.
  Assumes the link master model and the bound port checker.
*/
`timescale 1ns/1ns

module tb_top;
  import pwc_pkg::*;
  logic       i_clk_sys, i_rstn, i_ss_n, i_sck, i_mosi, o_miso, i_pwm, i_aux_oc;
  logic       i_glass_short, i_glass_above, i_low_voltage_fault_flag, i_high_voltage_fault_flag;
  logic [2:0] i_lamp_oc, o_lamp_switch;
  logic       o_aux_5v_output, o_aux_current_limit, o_supply_switch_transistor;
  logic       o_dac_output_transistor, o_glass_open_load_current, o_power_stage_enable;
  logic       o_stop_req, o_sleep_req, o_high_side_thermal_shutdown_select;
  logic       o_low_side_thermal_shutdown_select, o_voltage_shutdown_select;
  logic [5:0] o_glass_dac_code;
  logic [1:0] o_line_slew_select;
  int         err_total, check_count;
  int         stop_seen, sleep_seen;

  pwc_power_output_control #(.LAMPS(3)) uut (.i_clk_sys, .i_rstn, .i_ss_n, .i_sck, .i_mosi, .o_miso,
    .i_pwm, .i_lamp_oc, .i_aux_oc, .i_glass_short, .i_glass_above, .i_low_voltage_fault_flag,
    .i_high_voltage_fault_flag, .o_lamp_switch, .o_aux_5v_output, .o_aux_current_limit,
    .o_supply_switch_transistor, .o_dac_output_transistor, .o_glass_open_load_current,
    .o_glass_dac_code, .o_power_stage_enable, .o_stop_req, .o_sleep_req,
    .o_high_side_thermal_shutdown_select, .o_low_side_thermal_shutdown_select,
    .o_voltage_shutdown_select, .o_line_slew_select);

  pwc_link_master m (.i_clk_sys, .i_miso(o_miso), .o_ss_n(i_ss_n), .o_sck(i_sck), .o_mosi(i_mosi));

  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end

  // Request pulses last one cycle, so count them mid-cycle
  always @(negedge i_clk_sys) begin
    if (o_stop_req === 1'b1) stop_seen++;
    if (o_sleep_req === 1'b1) sleep_seen++;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : cyc

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    m.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] q;
    m.xfer(1'b0, a, 8'h00, q);
    chk($sformatf("register %h", a), q, e);
  endtask : rd

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    #200000;
    err_total++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    {i_rstn, i_pwm, i_aux_oc, i_glass_short, i_glass_above, i_lamp_oc} = '0;
    {i_low_voltage_fault_flag, i_high_voltage_fault_flag} = 2'b00;
    cyc(3);
    i_rstn = 1'b1;
    cyc(2);
    for (int i = 0; i < 7; i++) rd(i[3:0], 8'h00);
    wr(4'h1, 8'hff);
    rd(4'h1, 8'h00);
    $display("reset and map test done");
    wr(4'h0, 8'hff);
    rd(4'h0, 8'h9f);
    chk("system outputs", {o_power_stage_enable, 2'b00, o_low_side_thermal_shutdown_select,
      o_high_side_thermal_shutdown_select, o_voltage_shutdown_select, o_line_slew_select}, 8'h9f);
    wr(4'h0, 8'h40);
    chk("mode pulses", {stop_seen[3:0], sleep_seen[3:0]}, 8'h10);
    wr(4'h0, 8'h20);
    wr(4'h0, 8'h44);
    wr(4'h0, 8'h60);
    chk("mode pulses", {stop_seen[3:0], sleep_seen[3:0]}, 8'h11);
    rd(4'h0, 8'h00);
    wr(4'h0, 8'h80);
    $display("system control test done");
    wr(4'h2, 8'hff);
    rd(4'h2, 8'hbf);
    chk("aux output", 8'(o_aux_5v_output), 8'h01);
    chk("inrush lamps", 8'(o_lamp_switch), 8'h07);
    {i_low_voltage_fault_flag, i_high_voltage_fault_flag} = 2'b11;
    cyc(2);
    chk("lamps in voltage fault", 8'(o_lamp_switch), 8'h00);
    chk("aux in voltage fault", 8'(o_aux_5v_output), 8'h01);
    {i_low_voltage_fault_flag, i_high_voltage_fault_flag} = 2'b00;
    wr(4'h2, 8'h87);
    chk("on lamps", 8'(o_lamp_switch), 8'h07);
    i_lamp_oc = 3'b001;
    cyc(1);
    i_lamp_oc = 3'b000;
    cyc(2);
    chk("tripped lamp", 8'(o_lamp_switch), 8'h06);
    rd(4'h4, 8'h01);
    wr(4'h4, 8'h00);
    rd(4'h4, 8'h01);
    wr(4'h4, 8'h01);
    rd(4'h4, 8'h00);
    chk("re-enabled lamp", 8'(o_lamp_switch), 8'h07);
    $display("lamp on mode test done");
    wr(4'h2, 8'h38);
    i_pwm = 1'b1;
    cyc(2);
    chk("pwm high lamps", 8'(o_lamp_switch), 8'h07);
    i_pwm = 1'b0;
    cyc(2);
    chk("pwm low lamps", 8'(o_lamp_switch), 8'h00);
    i_pwm = 1'b1;
    cyc(1);
    i_lamp_oc = 3'b010;
    cyc(1);
    i_lamp_oc = 3'b000;
    cyc(2);
    chk("pwm tripped lamp", 8'(o_lamp_switch), 8'h05);
    i_pwm = 1'b0;
    cyc(2);
    i_pwm = 1'b1;
    cyc(2);
    chk("re-armed lamp", 8'(o_lamp_switch), 8'h07);
    i_pwm = 1'b0;
    rd(4'h4, 8'h02);
    wr(4'h4, 8'h02);
    $display("lamp pwm test done");
    wr(4'h2, 8'h80);
    i_aux_oc = 1'b1;
    cyc(2);
    chk("aux limiting", 8'({o_aux_current_limit, o_aux_5v_output}), 8'h03);
    rd(4'h4, 8'h08);
    wr(4'h4, 8'h08);
    rd(4'h4, 8'h08);
    i_aux_oc = 1'b0;
    wr(4'h4, 8'h08);
    rd(4'h4, 8'h00);
    wr(4'h2, 8'h87);
    wr(4'h0, 8'h00);
    chk("power off outputs", 8'({o_lamp_switch, o_aux_5v_output}), 8'h00);
    rd(4'h2, 8'h87);
    $display("aux and power test done");
    wr(4'h6, 8'hff);
    rd(4'h6, 8'h3f);
    chk("dac code", 8'(o_glass_dac_code), 8'h3f);
    wr(4'h5, 8'ha0);
    rd(4'h5, 8'ha0);
    chk("glass transistors", 8'({o_supply_switch_transistor, o_dac_output_transistor}), 8'h03);
    i_glass_short = 1'b1;
    cyc(1);
    i_glass_short = 1'b0;
    cyc(1);
    chk("shorted glass", 8'({o_supply_switch_transistor, o_dac_output_transistor}), 8'h00);
    rd(4'h5, 8'ha2);
    wr(4'h5, 8'ha2);
    chk("glass re-enabled", 8'({o_supply_switch_transistor, o_dac_output_transistor}), 8'h03);
    wr(4'h5, 8'he0);
    chk("glass in test", 8'({o_supply_switch_transistor, o_dac_output_transistor,
      o_glass_open_load_current}), 8'h01);
    i_glass_above = 1'b1;
    cyc(2);
    i_glass_above = 1'b0;
    rd(4'h5, 8'he1);
    wr(4'h5, 8'h81);
    rd(4'h5, 8'h00);
    $display("glass test done");
    tally_and_finish();
  end
endmodule : tb_top
